// >>> pair_exec_unit.sv
/*
  execution unit for paired instructions and the load/store/stack group.
  assumes a decoded instruction is offered on instr_valid_i while busy_o is
  low, and data memory answers a read one cycle after mem_rd_o.
*/
`timescale 1ns/1ps
module pair_exec_unit (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic instr_valid_i,
  input wire logic [3:0] kind_i,
  input wire logic [3:0] alu_i,
  input wire logic float_i,
  input wire logic subtract_i,
  input wire logic [2:0] reg_a_i,
  input wire logic [2:0] reg_b_i,
  input wire logic [2:0] dst_reg_i,
  input wire logic mul_dst_i,
  input wire logic add_dst_i,
  input wire logic [3:0] src_mode_i,
  input wire logic [23:0] ar_a_i,
  input wire logic [1:0] disp_a_i,
  input wire logic [23:0] ar_b_i,
  input wire logic [1:0] disp_b_i,
  input wire logic [23:0] index_reg_zero_i,
  input wire logic [23:0] index_reg_one_i,
  input wire logic cond_true_i,
  input wire logic [2:0] peek_idx_i,
  output logic [39:0] peek_data_o,
  output logic busy_o,
  output logic done_o,
  output logic illegal_o,
  output logic mem_rd_o,
  output logic [23:0] mem_addr_a_o,
  output logic [23:0] mem_addr_b_o,
  input wire logic [31:0] mem_rdata_a_i,
  input wire logic [31:0] mem_rdata_b_i,
  output logic mem_wr_a_o,
  output logic mem_wr_b_o,
  output logic [31:0] mem_wdata_a_o,
  output logic [31:0] mem_wdata_b_o,
  output logic [23:0] sp_o
);
  localparam int WW = pair_exec_pkg::WORD_W;
  localparam int XW = pair_exec_pkg::EXT_W;
  localparam int AW = pair_exec_pkg::ADDR_W;
  localparam int RW = pair_exec_pkg::REG_IDX_W;
  localparam int EW = pair_exec_pkg::EXP_W;
  localparam int MW = pair_exec_pkg::MEM_MAN_W;
  localparam int PW = pair_exec_pkg::PAD_W;
  localparam int EL = pair_exec_pkg::EXP_LSB;
  localparam int SW = pair_exec_pkg::SRC_OPS;
  localparam int NP = 3;

  typedef enum logic [1:0] {
    S_IDLE,
    S_FETCH,
    S_EXEC
  } state_t;

  // effective address of an indirect operand; only four displacements
  function automatic logic [AW-1:0] eff_addr(
    input logic [AW-1:0] base,
    input logic [1:0] disp,
    input logic [AW-1:0] ix0,
    input logic [AW-1:0] ix1
  );
    logic [AW-1:0] off;
    off = '0;
    case (pair_exec_pkg::disp_t'(disp))
      pair_exec_pkg::DISP_ZERO: off = '0;
      pair_exec_pkg::DISP_ONE: off = pair_exec_pkg::ADDR_ONE;
      pair_exec_pkg::DISP_INDEX_REG_ZERO: off = ix0;
      pair_exec_pkg::DISP_INDEX_REG_ONE: off = ix1;
      default: off = '0;
    endcase
    return base + off;
  endfunction

  // memory word to register image: float splits exponent and mantissa
  function automatic logic [XW-1:0] load_value(
    input logic as_float,
    input logic [WW-1:0] w
  );
    if (as_float)
      return {w[WW-1 -: EW], w[MW-1:0], {PW{1'b0}}};
    return {{EW{1'b0}}, w};
  endfunction

  // integer loads leave the exponent byte alone
  function automatic logic [1:0] load_lanes(input logic as_float);
    return as_float ? pair_exec_pkg::LANE_ALL : pair_exec_pkg::LANE_LOW;
  endfunction

  // register image to memory word; float drops the mantissa pad bits
  function automatic logic [WW-1:0] store_word(
    input logic as_float,
    input logic [XW-1:0] r
  );
    if (as_float)
      return {r[XW-1 -: EW], r[EL-1 -: MW]};
    return r[WW-1:0];
  endfunction

  // float forms share this integer datapath on the low word; a true
  // float unit is left outside this block to keep it small
  function automatic logic [WW-1:0] alu_op(
    input pair_exec_pkg::alu_t op,
    input logic [WW-1:0] a,
    input logic [WW-1:0] b
  );
    logic [WW-1:0] y;
    y = b;
    case (op)
      pair_exec_pkg::ALU_ADD: y = a + b;
      pair_exec_pkg::ALU_SUB: y = a - b;
      pair_exec_pkg::ALU_MUL: y = a * b;
      pair_exec_pkg::ALU_AND: y = a & b;
      pair_exec_pkg::ALU_OR: y = a | b;
      pair_exec_pkg::ALU_XOR: y = a ^ b;
      pair_exec_pkg::ALU_NEG: y = -b;
      pair_exec_pkg::ALU_NOT: y = ~b;
      pair_exec_pkg::ALU_ABS: y = b[WW-1] ? -b : b;
      default: y = b;
    endcase
    return y;
  endfunction

  // register-mode sources take port a then b, indirect ones memory a then b
  function automatic logic [WW-1:0] pick_op(
    input logic [SW-1:0] mode,
    input int pos,
    input logic [WW-1:0] ra,
    input logic [WW-1:0] rb,
    input logic [WW-1:0] ma,
    input logic [WW-1:0] mb
  );
    logic first;
    first = 1'b1;
    for (int j = 0; j < SW; j++)
      if (j < pos && mode[j] == mode[pos])
        first = 1'b0;
    if (mode[pos])
      return first ? ra : rb;
    return first ? ma : mb;
  endfunction

  // store and push forms need no memory read
  function automatic logic reads_memory(input pair_exec_pkg::kind_t k);
    case (k)
      pair_exec_pkg::KIND_STORE,
      pair_exec_pkg::KIND_PUSH,
      pair_exec_pkg::KIND_PAIR_STORE_STORE,
      pair_exec_pkg::KIND_NONE: return 1'b0;
      default: return 1'b1;
    endcase
  endfunction

  state_t state_r, state_nxt;
  pair_exec_pkg::kind_t kind_r, kind_nxt, kind_in;
  pair_exec_pkg::alu_t alu_r, alu_nxt;
  logic float_r, float_nxt, sub_r, sub_nxt, cond_r, cond_nxt;
  logic mul_dst_r, mul_dst_nxt, add_dst_r, add_dst_nxt;
  logic [RW-1:0] reg_a_r, reg_a_nxt, reg_b_r, reg_b_nxt, dst_r, dst_nxt;
  logic [SW-1:0] mode_r, mode_nxt;
  logic [AW-1:0] addr_a_r, addr_a_nxt, addr_b_r, addr_b_nxt;
  logic [AW-1:0] sp_r, sp_nxt;
  logic [WW-1:0] wdata_a_r, wdata_a_nxt, wdata_b_r, wdata_b_nxt;
  logic mem_rd_r, mem_rd_nxt, mem_wr_a_r, mem_wr_a_nxt;
  logic mem_wr_b_r, mem_wr_b_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, illegal_r, illegal_nxt;
  logic wr_a_en, wr_b_en;
  logic [RW-1:0] wr_a_idx, wr_b_idx;
  logic [1:0] wr_a_lane, wr_b_lane;
  logic [XW-1:0] wr_a_data, wr_b_data, ra_full, rb_full;
  logic [NP*XW-1:0] rd_data;
  logic [WW-1:0] ra_word, rb_word, mul_a, mul_b, add_a, add_b;
  logic [WW-1:0] product, sum;

  assign kind_in = pair_exec_pkg::kind_t'(kind_i);

  // sources are read from registered ports a cycle before the commit edge,
  // so a half reading a register sees it from before the other half writes
  ext_reg_file #(
    .RD_PORTS(NP)
  ) u_ext_reg_file (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .rd_idx_i({peek_idx_i, reg_b_r, reg_a_r}),
    .rd_data_o(rd_data),
    .wr_a_en_i(wr_a_en),
    .wr_a_idx_i(wr_a_idx),
    .wr_a_lane_i(wr_a_lane),
    .wr_a_data_i(wr_a_data),
    .wr_b_en_i(wr_b_en),
    .wr_b_idx_i(wr_b_idx),
    .wr_b_lane_i(wr_b_lane),
    .wr_b_data_i(wr_b_data)
  );

  // operand words of both halves
  assign ra_full = rd_data[0 +: XW];
  assign rb_full = rd_data[XW +: XW];
  assign ra_word = ra_full[WW-1:0];
  assign rb_word = rb_full[WW-1:0];
  assign mul_a = pick_op(mode_r, 0, ra_word, rb_word,
    mem_rdata_a_i, mem_rdata_b_i);
  assign mul_b = pick_op(mode_r, 1, ra_word, rb_word,
    mem_rdata_a_i, mem_rdata_b_i);
  assign add_a = pick_op(mode_r, 2, ra_word, rb_word,
    mem_rdata_a_i, mem_rdata_b_i);
  assign add_b = pick_op(mode_r, 3, ra_word, rb_word,
    mem_rdata_a_i, mem_rdata_b_i);
  assign product = alu_op(pair_exec_pkg::ALU_MUL, mul_a, mul_b);
  assign sum = sub_r ? add_a - add_b : add_a + add_b;

  // take, fetch, then execute and commit every result on one edge
  always_comb
  begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    alu_nxt = alu_r;
    float_nxt = float_r;
    sub_nxt = sub_r;
    cond_nxt = cond_r;
    mul_dst_nxt = mul_dst_r;
    add_dst_nxt = add_dst_r;
    reg_a_nxt = reg_a_r;
    reg_b_nxt = reg_b_r;
    dst_nxt = dst_r;
    mode_nxt = mode_r;
    addr_a_nxt = addr_a_r;
    addr_b_nxt = addr_b_r;
    sp_nxt = sp_r;
    wdata_a_nxt = wdata_a_r;
    wdata_b_nxt = wdata_b_r;
    mem_rd_nxt = 1'b0;
    mem_wr_a_nxt = 1'b0;
    mem_wr_b_nxt = 1'b0;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    illegal_nxt = 1'b0;
    wr_a_en = 1'b0;
    wr_a_idx = dst_r;
    wr_a_lane = load_lanes(float_r);
    wr_a_data = load_value(float_r, mem_rdata_a_i);
    wr_b_en = 1'b0;
    wr_b_idx = reg_b_r;
    wr_b_lane = load_lanes(float_r);
    wr_b_data = load_value(float_r, mem_rdata_b_i);
    case (state_r)
      S_IDLE:
        if (instr_valid_i)
        begin
          kind_nxt = kind_in;
          alu_nxt = pair_exec_pkg::alu_t'(alu_i);
          float_nxt = float_i;
          sub_nxt = subtract_i;
          cond_nxt = cond_true_i;
          mul_dst_nxt = mul_dst_i;
          add_dst_nxt = add_dst_i;
          reg_a_nxt = reg_a_i;
          reg_b_nxt = reg_b_i;
          dst_nxt = dst_reg_i;
          mode_nxt = src_mode_i;
          addr_a_nxt = eff_addr(ar_a_i, disp_a_i,
            index_reg_zero_i, index_reg_one_i);
          addr_b_nxt = eff_addr(ar_b_i, disp_b_i,
            index_reg_zero_i, index_reg_one_i);
          // a wrong mix of source modes is refused without going busy
          if (kind_in == pair_exec_pkg::KIND_PAIR_MUL_ADD &&
            $countones(src_mode_i) != pair_exec_pkg::REG_SRCS)
            illegal_nxt = 1'b1;
          else
          begin
            state_nxt = S_FETCH;
            busy_nxt = 1'b1;
            mem_rd_nxt = reads_memory(kind_in);
            if (kind_in == pair_exec_pkg::KIND_POP)
              addr_a_nxt = sp_r;
          end
        end
      S_FETCH:
        state_nxt = S_EXEC;
      S_EXEC:
      begin
        // both halves commit together on this edge
        state_nxt = S_IDLE;
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        case (kind_r)
          pair_exec_pkg::KIND_LOAD:
            wr_a_en = 1'b1;
          pair_exec_pkg::KIND_LOAD_EXP:
          begin
            wr_a_en = 1'b1;
            wr_a_lane = pair_exec_pkg::LANE_EXP;
            wr_a_data = load_value(1'b1, mem_rdata_a_i);
          end
          pair_exec_pkg::KIND_LOAD_MAN:
          begin
            wr_a_en = 1'b1;
            wr_a_lane = pair_exec_pkg::LANE_LOW;
            wr_a_data = load_value(1'b1, mem_rdata_a_i);
          end
          pair_exec_pkg::KIND_LOAD_COND:
            wr_a_en = cond_r;
          pair_exec_pkg::KIND_STORE:
          begin
            mem_wr_a_nxt = 1'b1;
            wdata_a_nxt = store_word(float_r, ra_full);
          end
          pair_exec_pkg::KIND_PUSH:
          begin
            // stack grows upward: step first, then write the new top
            sp_nxt = sp_r + pair_exec_pkg::ADDR_ONE;
            addr_a_nxt = sp_r + pair_exec_pkg::ADDR_ONE;
            mem_wr_a_nxt = 1'b1;
            wdata_a_nxt = store_word(float_r, ra_full);
          end
          pair_exec_pkg::KIND_POP:
          begin
            wr_a_en = 1'b1;
            sp_nxt = sp_r - pair_exec_pkg::ADDR_ONE;
          end
          pair_exec_pkg::KIND_PAIR_ARITH_STORE:
          begin
            wr_a_en = 1'b1;
            if (alu_r != pair_exec_pkg::ALU_PASS)
            begin
              wr_a_lane = pair_exec_pkg::LANE_LOW;
              wr_a_data = {{EW{1'b0}}, alu_op(alu_r, ra_word, mem_rdata_a_i)};
            end
            mem_wr_b_nxt = 1'b1;
            wdata_b_nxt = store_word(float_r, rb_full);
          end
          pair_exec_pkg::KIND_PAIR_STORE_STORE:
          begin
            mem_wr_a_nxt = 1'b1;
            wdata_a_nxt = store_word(float_r, ra_full);
            mem_wr_b_nxt = 1'b1;
            wdata_b_nxt = store_word(float_r, rb_full);
          end
          pair_exec_pkg::KIND_PAIR_LOAD:
          begin
            wr_a_en = 1'b1;
            wr_b_en = 1'b1;
          end
          pair_exec_pkg::KIND_PAIR_MUL_ADD:
          begin
            wr_a_en = 1'b1;
            wr_a_idx = pair_exec_pkg::MUL_DST_BASE | RW'(mul_dst_r);
            wr_a_lane = pair_exec_pkg::LANE_LOW;
            wr_a_data = {{EW{1'b0}}, product};
            wr_b_en = 1'b1;
            wr_b_idx = pair_exec_pkg::ADD_DST_BASE | RW'(add_dst_r);
            wr_b_lane = pair_exec_pkg::LANE_LOW;
            wr_b_data = {{EW{1'b0}}, sum};
          end
          default:
            done_nxt = 1'b1;
        endcase
      end
      default:
        state_nxt = S_IDLE;
    endcase
  end

  // state registers only
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r <= S_IDLE;
      kind_r <= pair_exec_pkg::KIND_NONE;
      alu_r <= pair_exec_pkg::ALU_PASS;
      float_r <= 1'b0;
      sub_r <= 1'b0;
      cond_r <= 1'b0;
      mul_dst_r <= 1'b0;
      add_dst_r <= 1'b0;
      reg_a_r <= '0;
      reg_b_r <= '0;
      dst_r <= '0;
      mode_r <= '0;
      addr_a_r <= '0;
      addr_b_r <= '0;
      sp_r <= pair_exec_pkg::SP_RESET;
      wdata_a_r <= '0;
      wdata_b_r <= '0;
      mem_rd_r <= 1'b0;
      mem_wr_a_r <= 1'b0;
      mem_wr_b_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      illegal_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      alu_r <= alu_nxt;
      float_r <= float_nxt;
      sub_r <= sub_nxt;
      cond_r <= cond_nxt;
      mul_dst_r <= mul_dst_nxt;
      add_dst_r <= add_dst_nxt;
      reg_a_r <= reg_a_nxt;
      reg_b_r <= reg_b_nxt;
      dst_r <= dst_nxt;
      mode_r <= mode_nxt;
      addr_a_r <= addr_a_nxt;
      addr_b_r <= addr_b_nxt;
      sp_r <= sp_nxt;
      wdata_a_r <= wdata_a_nxt;
      wdata_b_r <= wdata_b_nxt;
      mem_rd_r <= mem_rd_nxt;
      mem_wr_a_r <= mem_wr_a_nxt;
      mem_wr_b_r <= mem_wr_b_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      illegal_r <= illegal_nxt;
    end
  end

  // every output is a flop; the peek port is the file's registered read
  assign peek_data_o = rd_data[2*XW +: XW];
  assign busy_o = busy_r;
  assign done_o = done_r;
  assign illegal_o = illegal_r;
  assign mem_rd_o = mem_rd_r;
  assign mem_addr_a_o = addr_a_r;
  assign mem_addr_b_o = addr_b_r;
  assign mem_wr_a_o = mem_wr_a_r;
  assign mem_wr_b_o = mem_wr_b_r;
  assign mem_wdata_a_o = wdata_a_r;
  assign mem_wdata_b_o = wdata_b_r;
  assign sp_o = sp_r;
endmodule // pair_exec_unit

// >>> pair_exec_pkg.sv
/*
  constants, field layouts and command encodings shared by the paired
  and load/store execution unit and its register file.
  assumes a single core clock and a decode stage that has already split
  the instruction word into kind, operation and operand fields.
*/
package pair_exec_pkg;
  localparam int WORD_W = 32;
  localparam int EXT_W = 40;
  localparam int ADDR_W = 24;
  localparam int REG_IDX_W = 3;
  localparam int NUM_REGS = 8;
  localparam int EXP_LSB = 32;
  localparam int EXP_W = 8;
  localparam int MEM_MAN_W = 24;
  localparam int PAD_W = 8;
  localparam int LANE_W = 2;
  localparam int SRC_OPS = 4;
  localparam int REG_SRCS = 2;
  // write lanes of an extended register: exponent byte and low word
  localparam logic [1:0] LANE_EXP = 2'h2;
  localparam logic [1:0] LANE_LOW = 2'h1;
  localparam logic [1:0] LANE_ALL = 2'h3;
  // fixed destination bases for the multiply/add pair
  localparam logic [2:0] MUL_DST_BASE = 3'h0;
  localparam logic [2:0] ADD_DST_BASE = 3'h2;
  localparam logic [23:0] SP_RESET = 24'h000000;
  localparam logic [23:0] ADDR_ONE = 24'h000001;

  typedef enum logic [1:0] {
    DISP_ZERO,
    DISP_ONE,
    DISP_INDEX_REG_ZERO,
    DISP_INDEX_REG_ONE
  } disp_t;

  typedef enum logic [3:0] {
    KIND_NONE,
    KIND_LOAD,
    KIND_LOAD_EXP,
    KIND_LOAD_MAN,
    KIND_LOAD_COND,
    KIND_STORE,
    KIND_PUSH,
    KIND_POP,
    KIND_PAIR_ARITH_STORE,
    KIND_PAIR_STORE_STORE,
    KIND_PAIR_LOAD,
    KIND_PAIR_MUL_ADD
  } kind_t;

  typedef enum logic [3:0] {
    ALU_ADD,
    ALU_SUB,
    ALU_MUL,
    ALU_AND,
    ALU_OR,
    ALU_XOR,
    ALU_NEG,
    ALU_NOT,
    ALU_ABS,
    ALU_PASS
  } alu_t;
endpackage

// >>> ext_reg_file.sv
/*
  eight extended-precision registers with registered read ports and two
  lane-masked write ports.
  assumes writes are committed on one edge; port b wins a same-index clash.
*/
`timescale 1ns/1ps
module ext_reg_file #(
  parameter int RD_PORTS = 3
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [RD_PORTS*3-1:0] rd_idx_i,
  output logic [RD_PORTS*40-1:0] rd_data_o,
  input wire logic wr_a_en_i,
  input wire logic [2:0] wr_a_idx_i,
  input wire logic [1:0] wr_a_lane_i,
  input wire logic [39:0] wr_a_data_i,
  input wire logic wr_b_en_i,
  input wire logic [2:0] wr_b_idx_i,
  input wire logic [1:0] wr_b_lane_i,
  input wire logic [39:0] wr_b_data_i
);
  localparam int W = pair_exec_pkg::EXT_W;
  localparam int E = pair_exec_pkg::EXP_LSB;
  logic [W-1:0] regs_r [pair_exec_pkg::NUM_REGS];
  logic [W-1:0] regs_nxt [pair_exec_pkg::NUM_REGS];

  // lane-masked update; port b last so it wins a clash
  always_comb
  begin
    for (int i = 0; i < pair_exec_pkg::NUM_REGS; i++)
    begin
      regs_nxt[i] = regs_r[i];
      if (wr_a_en_i && wr_a_idx_i == 3'(i))
      begin
        if (wr_a_lane_i[1]) regs_nxt[i][W-1:E] = wr_a_data_i[W-1:E];
        if (wr_a_lane_i[0]) regs_nxt[i][E-1:0] = wr_a_data_i[E-1:0];
      end
      if (wr_b_en_i && wr_b_idx_i == 3'(i))
      begin
        if (wr_b_lane_i[1]) regs_nxt[i][W-1:E] = wr_b_data_i[W-1:E];
        if (wr_b_lane_i[0]) regs_nxt[i][E-1:0] = wr_b_data_i[E-1:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      for (int i = 0; i < pair_exec_pkg::NUM_REGS; i++)
        regs_r[i] <= '0;
    else
      regs_r <= regs_nxt;
  end

  // read data registered; a read sees the value before this edge's write
  genvar p;
  generate
    for (p = 0; p < RD_PORTS; p++)
    begin : g_rd
      logic [W-1:0] rd_r;
      always_ff @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
          rd_r <= '0;
        else
          rd_r <= regs_r[rd_idx_i[p*3 +: 3]];
      end
      assign rd_data_o[p*W +: W] = rd_r;
    end
  endgenerate
endmodule // ext_reg_file

// >>> pair_exec_checker.sv
/* timing checks on the pair execution unit
   bound onto the unit's own ports */
`timescale 1ns/1ps
module pair_exec_checker (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic instr_valid_i,
  input wire logic [3:0] kind_i,
  input wire logic [3:0] src_mode_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic illegal_o,
  input wire logic mem_wr_a_o,
  input wire logic mem_wr_b_o,
  input wire logic [23:0] sp_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // a request is taken when valid meets an idle unit
  logic take;
  assign take = instr_valid_i && !busy_o;
  sequence mix_s(n);
    take && kind_i == pair_exec_pkg::KIND_PAIR_MUL_ADD &&
      (($countones(src_mode_i) == 2) == n);
  endsequence
  // memory stays untouched over the three cycles of a read-only request
  property quiet_p(k);
    take && kind_i == k |-> (!mem_wr_a_o && !mem_wr_b_o) [*3];
  endproperty
  a_done_bound: assert property (take |-> ##[0:8] done_o || illegal_o)
    else $error("late done");
  a_busy_bound: assert property ($rose(busy_o) |-> ##[1:8] !busy_o)
    else $error("busy stuck");
  a_mix_refused: assert property (mix_s(0) |-> ##[0:8] illegal_o)
    else $error("bad mix taken");
  a_mix_taken: assert property (mix_s(1) |-> !illegal_o [*3])
    else $error("good mix refused");
  a_refused_quiet: assert property (illegal_o |-> !mem_wr_a_o && !mem_wr_b_o)
    else $error("refused op wrote");
  a_sp_step: assert property (sp_o != $past(sp_o) |->
    sp_o - $past(sp_o) == 24'h1 || $past(sp_o) - sp_o == 24'h1)
    else $error("stack jump");
  a_load_quiet: assert property (quiet_p(pair_exec_pkg::KIND_LOAD))
    else $error("load wrote");
  a_pop_quiet: assert property (quiet_p(pair_exec_pkg::KIND_POP))
    else $error("pop wrote");
endmodule // pair_exec_checker
bind pair_exec_unit pair_exec_checker u_pair_exec_checker (.*);

// >>> testbench.sv
/* bench for the pair execution unit with a word model of registers
   assumes memory reads answer one cycle after the address */
`timescale 1ns/1ps
module testbench;
  logic clk_i, nrst_i, instr_valid_i, float_i, subtract_i, mul_dst_i;
  logic add_dst_i, cond_true_i, busy_o, done_o, illegal_o, mem_rd_o, bad;
  logic mem_wr_a_o, mem_wr_b_o;
  logic [1:0] disp_a_i, disp_b_i;
  logic [2:0] reg_a_i, reg_b_i, dst_reg_i, peek_idx_i;
  logic [3:0] kind_i, alu_i, src_mode_i;
  logic [23:0] ar_a_i, ar_b_i, index_reg_zero_i, index_reg_one_i, sp_o, wa;
  logic [23:0] mem_addr_a_o, mem_addr_b_o;
  logic [31:0] mem_rdata_a_i, mem_rdata_b_i, mem_wdata_a_o, mem_wdata_b_o;
  logic [31:0] wd, s, pk;
  logic [39:0] peek_data_o;
  logic [31:0] m [8];
  int errors = 0;
  int checks = 0;
  pair_exec_unit u_pair_exec_unit (.*);
  // the dsp core clock, 100 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  function automatic logic [31:0] mf(input logic [23:0] a);
    return {~a[7:0], a};
  endfunction
  function automatic logic [23:0] ea(input logic [23:0] a, logic [1:0] d);
    return a + (d[1] ? (d[0] ? index_reg_one_i : index_reg_zero_i) : 24'(d));
  endfunction
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // one remembered word keeps the stack honest; the rest reads as mf
  always @(posedge clk_i)
  begin
    mem_rdata_a_i <= mem_addr_a_o == wa ? wd : mf(mem_addr_a_o);
    mem_rdata_b_i <= mem_addr_b_o == wa ? wd : mf(mem_addr_b_o);
    if (!nrst_i)
      {wa, wd} <= '0;
    else if (mem_wr_a_o | mem_wr_b_o)
      {wa, wd} <= mem_wr_b_o ? {mem_addr_b_o, mem_wdata_b_o} :
        {mem_addr_a_o, mem_wdata_a_o};
  end
  task chk(input logic [39:0] g, e);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // done or refusal ends the wait; the peek port lags by a cycle
  task go(input logic [3:0] k, input logic [2:0] r);
    kind_i <= k;
    dst_reg_i <= r;
    peek_idx_i <= r;
    instr_valid_i <= 1'b1;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    @(negedge clk_i);
    for (int n = 0; n < 9 && done_o !== 1'b1 && illegal_o !== 1'b1; n++)
      @(negedge clk_i);
    bad = illegal_o;
    repeat (2) @(negedge clk_i);
    pk = peek_data_o[31:0];
    @(posedge clk_i);
  endtask
  initial
  begin
    {nrst_i, instr_valid_i, float_i, subtract_i, mul_dst_i} <= '0;
    {add_dst_i, cond_true_i, disp_a_i, disp_b_i, reg_a_i, reg_b_i} <= '0;
    {dst_reg_i, peek_idx_i, kind_i, alu_i, src_mode_i, ar_a_i, ar_b_i} <= '0;
    {index_reg_zero_i, index_reg_one_i} <= '0;
    s = 32'h5b260aa4;
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    index_reg_zero_i <= s[23:0];
    index_reg_one_i <= s[31:8];
    @(posedge clk_i);
    // every register once, cycling through the four displacements, then false/true cond
    for (int r = 0; r < 10; r++)
    begin
      s = nx(s);
      ar_a_i <= s[23:0];
      disp_a_i <= r[1:0];
      cond_true_i <= r[0];
      go(r < 8 ? pair_exec_pkg::KIND_LOAD : pair_exec_pkg::KIND_LOAD_COND,
        r[2:0]);
      if (r < 8 || r[0])
        m[r[2:0]] = mf(ea(s[23:0], r[1:0]));
      chk(pk, m[r[2:0]]);
    end
    reg_a_i <= 3'h5;
    go(pair_exec_pkg::KIND_STORE, 3'h5);
    chk(wd, m[5]);
    alu_i <= pair_exec_pkg::ALU_XOR;
    reg_a_i <= 3'h1;
    reg_b_i <= 3'h6;
    go(pair_exec_pkg::KIND_PAIR_ARITH_STORE, 3'h1);
    chk(wd, m[6]);
    chk(pk, m[1] ^ m[5]);
    reg_a_i <= 3'h4;
    go(pair_exec_pkg::KIND_PUSH, 3'h4);
    go(pair_exec_pkg::KIND_POP, 3'h0);
    chk(pk, m[4]);
    // sum lands in the first add register: memory a plus word 0, read as mf since the push replaced the store to it
    src_mode_i <= 4'h3;
    go(pair_exec_pkg::KIND_PAIR_MUL_ADD, 3'h2);
    chk(pk, 32'(mf(ea(ar_a_i, disp_a_i)) + mf(24'h0)));
    for (int v = 3; v < 8; v += 4)
    begin
      src_mode_i <= v[3:0];
      go(pair_exec_pkg::KIND_PAIR_MUL_ADD, 3'h0);
      chk(bad, v == 7);
      if (v == 3)
        chk(pk, 32'(m[4] * m[6]));
    end
    reg_b_i <= 3'h7;
    go(pair_exec_pkg::KIND_PAIR_LOAD, 3'h3);
    chk(pk, mf(ea(ar_a_i, disp_a_i)));
    float_i <= 1'b1;
    go(pair_exec_pkg::KIND_LOAD, 3'h5);
    chk(pk, 32'({mf(ea(ar_a_i, disp_a_i)), 8'h00}));
    end_of_test();
  end
  // some twenty requests of under thirty cycles each
  initial
  begin
    #400000;
    errors++;
    end_of_test();
  end
  task end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
endmodule // testbench
